/* common/cscap_pkg.sv */
// Package for the colour sensor capacitor-count configuration block.
// Assumes a single 40 MHz core clock; no imports anywhere.
package cscap_pkg;

  // Two-wire slave address and register addresses
  localparam logic [6:0] SLAVE_ADDR     = 7'h74;
  localparam logic [7:0] ADDR_RED_CAP   = 8'h06;
  localparam logic [7:0] ADDR_GREEN_CAP = 8'h07;
  localparam logic [7:0] ADDR_BLUE_CAP  = 8'h08;
  localparam logic [7:0] ADDR_CLEAR_CAP = 8'h09;

  // Field layout and reset values
  localparam int         CAP_W         = 4;
  localparam logic [3:0] CAP_RESET_VAL = 4'hF;
  localparam int         NUM_CHAN      = 4;

  // Reset pulse limit, kept for the bench
  localparam int CLK_PERIOD_PS    = 25000;
  localparam int RESET_MIN_NS     = 1000;
  localparam int RESET_MIN_CYCLES = (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [2:0] {
    CSCAP_IDLE,
    CSCAP_RX,
    CSCAP_ACK,
    CSCAP_TX,
    CSCAP_TX_ACK
  } cscap_state_e;

  // Capacitor settings, one nibble per channel
  typedef struct packed {
    logic [3:0] red;
    logic [3:0] green;
    logic [3:0] blue;
    logic [3:0] clear;
  } cscap_caps_s;

  // Capacitor selections driven to the analog array
  typedef struct packed {
    logic [4:0] red;
    logic [4:0] green;
    logic [4:0] blue;
    logic [4:0] clear;
  } cscap_sel_s;

endpackage

/* core/cscap_sync.sv */
// Two-flop synchroniser for one pin level.
// Assumes the input is asynchronous to i_ref_clk.
`timescale 1ns/1ps
`default_nettype none
module cscap_sync
#(
  parameter logic RST_VAL = 1'b1
)
(
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  input  wire logic i_async,
  output logic      o_sync
);

  typedef struct packed {
    logic meta;
    logic sync;
  } cscap_sync_s;

  cscap_sync_s state_reg;
  cscap_sync_s state_next;

  // First stage feeds only the second
  always_comb
  begin
    state_next.meta = i_async;
    state_next.sync = state_reg.meta;
  end

  // Reset value is a parameter, never logic, so the reset branch stays constant
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_reg <= {2{RST_VAL}};
    else
      state_reg <= state_next;
  end

  assign o_sync = state_reg.sync;

endmodule // cscap_sync
`default_nettype wire

/* core/cscap_config.sv */
// Capacitor-count configuration registers behind a two-wire slave port.
// Assumes an external pull-up on the data pin and an external reset pulse.
//
// Operation
// - Every capacitor-count register resets to 0x0F, the largest selection.
// - Count value n selects n plus one capacitors, one to sixteen.
// - Red, green, blue and clear each keep an independent count.
// - Sleep high powers analog down and freezes the core logic.
// - Active-low reset loads every register's reset value at once, without a clock.
// - Data pin is never driven high; a one releases the pin.
// - Red, green, blue, clear counts sit at addresses 0x06 to 0x09.
// - Slave address 0x74; write is address, register, data, each acknowledged.
`timescale 1ns/1ps
`default_nettype none
module cscap_config
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_sleep,
  input  wire logic              i_serial_clock_in,
  input  wire logic              i_serial_data_in,
  output logic                   o_serial_data_out,
  output logic                   o_serial_data_oe_n,
  output cscap_pkg::cscap_caps_s o_caps,
  output cscap_pkg::cscap_sel_s  o_cap_sel,
  output logic                   o_analog_pd
);

  typedef struct packed {
    cscap_pkg::cscap_state_e st;
    logic                    scl_d;
    logic                    sda_d;
    logic [3:0]              bit_cnt;
    logic [7:0]              shift;
    logic [1:0]              byte_idx;
    logic                    rd_mode;
    logic [7:0]              reg_addr;
    logic                    drive_low;
    cscap_pkg::cscap_caps_s  caps;
    cscap_pkg::cscap_sel_s   sel;
    logic                    pd;
  } cscap_cfg_s;

  cscap_cfg_s state_reg;
  cscap_cfg_s state_next;
  logic       scl_s;
  logic       sda_s;
  logic       sleep_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic [7:0] rd_data;
  logic       run_en;

  // Pins pass two flops before any logic looks at them
  cscap_sync
  #(
    .RST_VAL (1'b1)
  )
  u_sync_scl
  (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_serial_clock_in),
    .o_sync    (scl_s)
  );

  cscap_sync
  #(
    .RST_VAL (1'b1)
  )
  u_sync_sda
  (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_serial_data_in),
    .o_sync    (sda_s)
  );

  // Sleep synchroniser resets high so the core stays frozen until the pin is seen low
  cscap_sync
  #(
    .RST_VAL (1'b1)
  )
  u_sync_sleep
  (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_sleep),
    .o_sync    (sleep_s)
  );

  // Edge and bus-condition detection on synchronised levels
  assign scl_rise = scl_s & ~state_reg.scl_d;
  assign scl_fall = ~scl_s & state_reg.scl_d;
  assign start_c  = scl_s & state_reg.scl_d & state_reg.sda_d & ~sda_s;
  assign stop_c   = scl_s & state_reg.scl_d & ~state_reg.sda_d & sda_s;
  assign run_en   = ~sleep_s;

  // Readback mux; unmapped addresses read zero
  always_comb
  begin
    rd_data = 8'h00;
    case (state_reg.reg_addr)
      cscap_pkg::ADDR_RED_CAP   : rd_data = {4'h0, state_reg.caps.red};
      cscap_pkg::ADDR_GREEN_CAP : rd_data = {4'h0, state_reg.caps.green};
      cscap_pkg::ADDR_BLUE_CAP  : rd_data = {4'h0, state_reg.caps.blue};
      cscap_pkg::ADDR_CLEAR_CAP : rd_data = {4'h0, state_reg.caps.clear};
      default                   : rd_data = 8'h00;
    endcase
  end

  // Protocol engine: bytes shift in on rising SCL, ACK and data change on falling SCL
  always_comb
  begin
    state_next       = state_reg;
    state_next.scl_d = scl_s;
    state_next.sda_d = sda_s;
    state_next.pd    = sleep_s;
    if (start_c)
    begin
      state_next.st        = cscap_pkg::CSCAP_RX;
      state_next.bit_cnt   = 4'h0;
      state_next.byte_idx  = 2'h0;
      state_next.drive_low = 1'b0;
    end
    else if (stop_c)
    begin
      state_next.st        = cscap_pkg::CSCAP_IDLE;
      state_next.drive_low = 1'b0;
    end
    else
    begin
      case (state_reg.st)
        cscap_pkg::CSCAP_IDLE :
          state_next.drive_low = 1'b0;
        cscap_pkg::CSCAP_RX :
        begin
          if (scl_rise)
          begin
            state_next.shift   = {state_reg.shift[6:0], sda_s};
            state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
          end
          else if (scl_fall && state_reg.bit_cnt == 4'h8)
          begin
            state_next.bit_cnt = 4'h0;
            state_next.st      = cscap_pkg::CSCAP_ACK;
            if (state_reg.byte_idx == 2'h0)
            begin
              // Foreign address: release the bus until next START
              if (state_reg.shift[7:1] == cscap_pkg::SLAVE_ADDR)
              begin
                state_next.drive_low = 1'b1;
                state_next.rd_mode   = state_reg.shift[0];
              end
              else
                state_next.st = cscap_pkg::CSCAP_IDLE;
            end
            else if (state_reg.byte_idx == 2'h1)
            begin
              state_next.reg_addr  = state_reg.shift;
              state_next.drive_low = 1'b1;
            end
            else
            begin
              state_next.drive_low = 1'b1;
              case (state_reg.reg_addr)
                cscap_pkg::ADDR_RED_CAP   : state_next.caps.red   = state_reg.shift[3:0];
                cscap_pkg::ADDR_GREEN_CAP : state_next.caps.green = state_reg.shift[3:0];
                cscap_pkg::ADDR_BLUE_CAP  : state_next.caps.blue  = state_reg.shift[3:0];
                cscap_pkg::ADDR_CLEAR_CAP : state_next.caps.clear = state_reg.shift[3:0];
                default                   : state_next.caps = state_reg.caps;
              endcase
            end
          end
        end
        cscap_pkg::CSCAP_ACK :
        begin
          // ACK bit spans one SCL low-high-low; release on its falling edge
          if (scl_fall)
          begin
            state_next.drive_low = 1'b0;
            if (state_reg.byte_idx == 2'h0 && state_reg.rd_mode)
            begin
              state_next.st        = cscap_pkg::CSCAP_TX;
              state_next.shift     = rd_data;
              state_next.drive_low = ~rd_data[7];
              state_next.bit_cnt   = 4'h1;
            end
            else
            begin
              state_next.st = cscap_pkg::CSCAP_RX;
              if (state_reg.byte_idx != 2'h3)
                state_next.byte_idx = state_reg.byte_idx + 2'h1;
            end
          end
        end
        cscap_pkg::CSCAP_TX :
        begin
          if (scl_fall)
          begin
            if (state_reg.bit_cnt == 4'h8)
            begin
              state_next.drive_low = 1'b0;
              state_next.st        = cscap_pkg::CSCAP_TX_ACK;
            end
            else
            begin
              state_next.drive_low = ~state_reg.shift[3'(4'h7 - state_reg.bit_cnt)];
              state_next.bit_cnt   = state_reg.bit_cnt + 4'h1;
            end
          end
        end
        cscap_pkg::CSCAP_TX_ACK :
        begin
          // Master NACK ends the read; ACK resends the same byte
          if (scl_rise)
          begin
            if (sda_s)
              state_next.st = cscap_pkg::CSCAP_IDLE;
            else
            begin
              state_next.st      = cscap_pkg::CSCAP_ACK;
              state_next.byte_idx = 2'h0;
            end
          end
        end
        default :
          state_next.st = cscap_pkg::CSCAP_IDLE;
      endcase
    end
    // Capacitor selection is count plus one
    state_next.sel.red   = {1'b0, state_next.caps.red}   + 5'h01;
    state_next.sel.green = {1'b0, state_next.caps.green} + 5'h01;
    state_next.sel.blue  = {1'b0, state_next.caps.blue}  + 5'h01;
    state_next.sel.clear = {1'b0, state_next.caps.clear} + 5'h01;
  end

  // Sleep acts as a clock gate: state holds, only power-down flag tracks
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg            <= '0;
      state_reg.st         <= cscap_pkg::CSCAP_IDLE;
      state_reg.scl_d      <= 1'b1;
      state_reg.sda_d      <= 1'b1;
      state_reg.pd         <= 1'b1;
      state_reg.caps.red   <= cscap_pkg::CAP_RESET_VAL;
      state_reg.caps.green <= cscap_pkg::CAP_RESET_VAL;
      state_reg.caps.blue  <= cscap_pkg::CAP_RESET_VAL;
      state_reg.caps.clear <= cscap_pkg::CAP_RESET_VAL;
      state_reg.sel        <= {4{5'h10}};
    end
    else if (run_en)
      state_reg <= state_next;
    else
      state_reg.pd <= 1'b1;
  end

  // Pin drives only low; output value is a constant zero
  assign o_serial_data_out  = 1'b0;
  assign o_serial_data_oe_n = ~state_reg.drive_low;
  assign o_caps             = state_reg.caps;
  assign o_cap_sel          = state_reg.sel;
  assign o_analog_pd        = state_reg.pd;

endmodule // cscap_config
`default_nettype wire

/* test/cscap_properties.sv */
// Checker on the ports of the capacitor-count block.
// Assumes one 40 MHz core clock and the async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module cscap_props
(
  input wire logic                   i_ref_clk,
  input wire logic                   i_rst_n,
  input wire logic                   i_sleep,
  input wire logic                   i_serial_clock_in,
  input wire logic                   o_serial_data_out,
  input wire logic                   o_serial_data_oe_n,
  input wire cscap_pkg::cscap_caps_s o_caps,
  input wire cscap_pkg::cscap_sel_s  o_cap_sel,
  input wire logic                   o_analog_pd
);
  default clocking dclk @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // Selection must track every count, plus one
  chk_sel_match: assert property (
    o_cap_sel.red == o_caps.red + 5'h01 && o_cap_sel.green == o_caps.green + 5'h01
    && o_cap_sel.blue == o_caps.blue + 5'h01 && o_cap_sel.clear == o_caps.clear + 5'h01)
    else $error("selection is not count plus one");
  // First edge after release still shows reset values
  chk_reset_value: assert property ($rose(i_rst_n) |-> o_caps == 16'hFFFF
    && o_cap_sel == 20'h84210 && o_serial_data_oe_n) else $error("reset values wrong");
  chk_sda_no_high: assert property (o_serial_data_out == 1'b0)
    else $error("data pin driven high");
  // Sync adds latency, so allow a few edges before freezing
  chk_sleep_freeze: assert property (i_sleep[*5] |-> $stable(o_caps) && $stable(o_serial_data_oe_n))
    else $error("state moved in sleep");
  chk_sleep_pd: assert property (i_sleep[*5] |-> o_analog_pd)
    else $error("analog not powered down");
  chk_caps_on_ack: assert property ($changed(o_caps) |-> !o_serial_data_oe_n)
    else $error("count changed outside acknowledge");
  // Data pin may only move while the bus clock is low
  chk_sda_scl_low: assert property ($changed(o_serial_data_oe_n) |-> !$past(i_serial_clock_in, 2))
    else $error("data pin moved with clock high");
  chk_ack_hold: assert property ($fell(o_serial_data_oe_n) |=> (!o_serial_data_oe_n)[*5])
    else $error("pull-down too short");

  cov_ack: cover property ($fell(o_serial_data_oe_n));
  cov_write: cover property ($changed(o_caps));
  cov_sleep: cover property (i_sleep[*5]);
endmodule // cscap_props

bind cscap_config cscap_props cscap_props_i (.i_ref_clk, .i_rst_n, .i_sleep, .i_serial_clock_in,
  .o_serial_data_out, .o_serial_data_oe_n, .o_caps, .o_cap_sel, .o_analog_pd);
`default_nettype wire

/* test/cscap_host.sv */
// Two-wire bus master model driving the block's serial pins.
// Assumes the bench resolves the open-drain line with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module cscap_host
(
  input  wire logic i_ref_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  int lo_ns = 50; // Raise to stretch the low phase for a slow master

  // Idle bus: clock stands high, data released
  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // One clock pulse; data moves mid-low, sampled mid-high
  task automatic bit_cyc(input logic low, output logic smp);
    o_scl = 1'b0;
    #(lo_ns) o_sda_low = low;
    #(lo_ns) o_scl = 1'b1;
    #50 smp = i_sda;
    #50;
  endtask

  // Fresh frames start just after a core edge; all later steps stay on that grid
  task automatic start_c(input logic rep);
    logic s;
    if (rep)
      bit_cyc(1'b0, s);
    else
    begin
      @(posedge i_ref_clk);
      #2;
    end
    o_sda_low = 1'b1;
    #100;
  endtask

  task automatic stop_c();
    o_scl = 1'b0;
    #(lo_ns) o_sda_low = 1'b1;
    #(lo_ns) o_scl = 1'b1;
    #50 o_sda_low = 1'b0;
    #50;
  endtask

  task automatic tx(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cyc(!b[i], s);
    bit_cyc(1'b0, s);
    ack = !s;
  endtask

  task automatic rx(output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_cyc(1'b0, s);
      b[i] = s;
    end
    bit_cyc(1'b0, s); // Not-acknowledge ends the read
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] ra, dt, output logic [2:0] ak);
    start_c(1'b0);
    tx({dev, 1'b0}, ak[2]);
    tx(ra, ak[1]);
    tx(dt, ak[0]);
    stop_c();
  endtask

  task automatic rd(input logic [7:0] ra, output logic [7:0] dt);
    logic a;
    start_c(1'b0);
    tx({cscap_pkg::SLAVE_ADDR, 1'b0}, a);
    tx(ra, a);
    start_c(1'b1);
    tx({cscap_pkg::SLAVE_ADDR, 1'b1}, a);
    rx(dt);
    stop_c();
  endtask
endmodule // cscap_host
`default_nettype wire

/* test/cscap_config_bench.sv */
// Self-checking bench for the capacitor-count block.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module cscap_config_bench;
  logic                   ref_clk, rst_n, sleep, scl, sda_low, sda_out, oe_n, pd;
  wire                    sda;
  cscap_pkg::cscap_caps_s caps;
  cscap_pkg::cscap_sel_s  sel;
  int                     err_count, samples_checked;

  // Open-drain line with pull-up; any pull-down wins, a driven one would show high
  assign sda = !(sda_low || (!oe_n && !sda_out));

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = !ref_clk;
  end

  cscap_config cscap_config_i (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_sleep(sleep),
    .i_serial_clock_in(scl), .i_serial_data_in(sda), .o_serial_data_out(sda_out),
    .o_serial_data_oe_n(oe_n), .o_caps(caps), .o_cap_sel(sel), .o_analog_pd(pd));
  cscap_host cscap_host_i (.i_ref_clk(ref_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

  task automatic cmp(input logic [19:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Counts and the selections expected from them
  task automatic chk_state(input logic [15:0] c);
    logic [19:0] s;
    for (int i = 0; i < 4; i++)
      s[i*5 +: 5] = {1'b0, c[i*4 +: 4]} + 5'h01;
    cmp(caps, c, "counts");
    cmp(sel, s, "selection");
  endtask

  task automatic wake(input logic lv);
    @(posedge ref_clk);
    #2 sleep = lv;
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic t_reset();
    chk_state(16'hFFFF);
    cmp(oe_n, 1'b1, "data released");
    cmp(sda_out, 1'b0, "data value low");
    cmp(pd, 1'b0, "awake after reset");
    $display("reset test done");
  endtask

  task automatic t_write();
    logic [7:0]  ra [4];
    logic [7:0]  dv [4];
    logic [15:0] e;
    logic [2:0]  ak;
    logic [7:0]  rb;
    ra = '{cscap_pkg::ADDR_RED_CAP, cscap_pkg::ADDR_GREEN_CAP, cscap_pkg::ADDR_BLUE_CAP, cscap_pkg::ADDR_CLEAR_CAP};
    dv = '{8'hA5, 8'h00, 8'h0F, 8'h37};
    e = 16'hFFFF;
    for (int i = 0; i < 4; i++)
    begin
      cscap_host_i.wr(cscap_pkg::SLAVE_ADDR, ra[i], dv[i], ak);
      e[15 - i*4 -: 4] = dv[i][3:0];
      cmp(ak, 3'h7, "write acks");
      chk_state(e);
    end
    for (int i = 0; i < 4; i++)
    begin
      cscap_host_i.rd(ra[i], rb);
      cmp(rb, {4'h0, dv[i][3:0]}, "read back");
    end
    cscap_host_i.rd(8'h0A, rb);
    cmp(rb, 8'h00, "unmapped read");
    $display("write test done");
  endtask

  task automatic t_bad();
    logic [2:0] ak;
    cscap_host_i.wr(7'h75, cscap_pkg::ADDR_RED_CAP, 8'h02, ak);
    cmp(ak, 3'h0, "foreign address");
    chk_state(16'h50F7);
    cscap_host_i.wr(cscap_pkg::SLAVE_ADDR, 8'h05, 8'h02, ak);
    cmp(ak, 3'h7, "unmapped write acks");
    chk_state(16'h50F7);
    $display("refusal test done");
  endtask

  task automatic t_sleep();
    logic [2:0] ak;
    wake(1'b1);
    cmp(pd, 1'b1, "power down");
    cscap_host_i.wr(cscap_pkg::SLAVE_ADDR, cscap_pkg::ADDR_BLUE_CAP, 8'h01, ak);
    cmp(ak, 3'h0, "asleep acks");
    chk_state(16'h50F7);
    wake(1'b0);
    cmp(pd, 1'b0, "awake");
    $display("sleep test done");
  endtask

  // Slow master write, then reset between clock edges
  task automatic t_async();
    logic [2:0] ak;
    cscap_host_i.lo_ns = 150;
    cscap_host_i.wr(cscap_pkg::SLAVE_ADDR, cscap_pkg::ADDR_GREEN_CAP, 8'h09, ak);
    cscap_host_i.lo_ns = 50;
    cmp(ak, 3'h7, "slow write acks");
    chk_state(16'h59F7);
    @(posedge ref_clk);
    #2 rst_n = 1'b0;
    #3 chk_state(16'hFFFF);
    repeat (cscap_pkg::RESET_MIN_CYCLES) @(posedge ref_clk);
    #2 rst_n = 1'b1;
    repeat (8) @(posedge ref_clk);
    #2 chk_state(16'hFFFF);
    cmp(oe_n, 1'b1, "released after reset");
    $display("async reset test done");
  endtask

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Reset longer than 40 cycles: the pin needs a full microsecond
  // The first edge comes half a period in, so one edge more keeps the pulse long enough
  initial
  begin
    rst_n = 1'b0;
    sleep = 1'b0;
    repeat (cscap_pkg::RESET_MIN_CYCLES + 1) @(posedge ref_clk);
    #2 rst_n = 1'b1;
    repeat (8) @(posedge ref_clk);
    t_reset();
    t_write();
    t_bad();
    t_sleep();
    t_async();
    give_verdict();
  end

  // Whole run needs roughly 95 us of bus traffic
  initial
  begin
    #500000;
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule // cscap_config_bench
`default_nettype wire
